// File: hw/shp_regs.svh
`ifndef SHP_REGS_SVH
`define SHP_REGS_SVH

// status change flags carried by the interrupt logic
`define SHP_STAT_W 8
`define SHP_STAT_CLEAR 8'h00
// strap counter value reached after reset release (two sync stages plus one); the straps are caught on the next cycle
`define SHP_STRAP_WAIT 2'h3
`define SHP_CNT_ZERO 2'h0
`define SHP_CNT_ONE 2'h1
// level that selects two-wire mode on the bus kind strap
`define SHP_SEL_TWO_WIRE 1'h1
`define SHP_ADDR_ZERO 2'h0

`endif

// File: hw/shp_pkg.sv
package shp_pkg;

  typedef enum logic [1:0] {
    SHP_MODE_NONE = 2'b00,
    SHP_MODE_I2C = 2'b01,
    SHP_MODE_SPI3 = 2'b10,
    SHP_MODE_SPI4 = 2'b11
  } shp_mode_t;

  // levels seen on the input side of the serial port pins
  typedef struct packed {
    logic bus_sel;
    logic sdata;
    logic addr1;
    logic sclk;
    logic addr0_sel;
  } shp_pins_t;

  typedef struct packed {
    shp_pins_t meta;
    shp_pins_t stable;
  } shp_sync_t;

  // decoded port state handed to the protocol engine
  typedef struct packed {
    shp_mode_t mode;
    logic selected;
    logic sclk_level;
    logic sclk_rise;
    logic sclk_fall;
    logic data_in;
    logic [1:0] dev_addr;
  } shp_link_t;

  // what the protocol engine wants to put on the wire
  typedef struct packed {
    logic tx_en;
    logic tx_bit;
  } shp_tx_t;

  // one pin driver: output level and enable
  typedef struct packed {
    logic o;
    logic oe;
  } shp_drv_t;

endpackage : shp_pkg

// File: hw/shp_pin_sync.sv
`timescale 1ns/10ps
module shp_pin_sync
  import shp_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic reset_n, // synchronous reset
  input wire shp_pins_t pins_a, // raw pin levels
  output shp_pins_t pins_s // levels after two flops
);
  shp_sync_t st_r;
  shp_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins_a;
    // first stage feeds only the second
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_s = st_r.stable;

endmodule : shp_pin_sync

// File: hw/shp_serial_port.sv
// Overview of operation
// - strap high selects two-wire bus mode, strap low selects SPI mode
// - in two-wire mode the data pin is shared, both sides may drive it
// - three-wire SPI uses data pin both ways; four-wire SPI only as input
// - four-wire SPI drives address-one pin as serial data output
// - two-wire mode samples address-one pin as device address bit one
// - serial clock is always an input supplied by the host
// - two-wire mode samples address-zero pin as device address bit zero
// - SPI mode treats address-zero pin as active-low chip select
// - interrupt output goes low when any unmasked status change is pending
`timescale 1ns/10ps
`include "shp_regs.svh"
module shp_serial_port
  import shp_pkg::*;
(
  input wire logic ref_clk, // 125 MHz core clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic bus_sel_pin, // bus kind strap
  input wire logic sdata_i, // shared data pin, input side
  output logic sdata_o, // shared data pin, output level
  output logic sdata_oe, // shared data pin, drive enable
  input wire logic address_one_data_out_pin_i, // address one / data out, input side
  output logic address_one_data_out_pin_o, // address one / data out, level
  output logic address_one_data_out_pin_oe, // address one / data out, enable
  input wire logic sclk_pin, // serial clock from host
  input wire logic address_zero_select_pin, // address zero / chip select
  input wire logic spi_three_wire, // spi flavour, caught with the strap
  input wire shp_tx_t tx, // engine transmit request
  output shp_link_t link, // decoded port state to engine
  input wire logic [`SHP_STAT_W-1:0] status_event, // status change pulses
  input wire logic [`SHP_STAT_W-1:0] status_mask, // one enables a flag
  input wire logic [`SHP_STAT_W-1:0] status_clear, // one clears a flag
  output logic [`SHP_STAT_W-1:0] status_flags, // sticky change flags
  output logic status_change_irq_n // interrupt, active low
);

  typedef struct packed {
    logic [1:0] strap_cnt;
    logic locked;
    logic prev_sclk;
    shp_link_t link;
    shp_drv_t sdata;
    shp_drv_t addr1;
    logic [`SHP_STAT_W-1:0] flags;
    logic irq_n;
  } shp_state_t;

  shp_state_t st_r;
  shp_state_t st_nxt;
  shp_pins_t pins_a;
  shp_pins_t pins_s;
  logic sel_now;
  logic [`SHP_STAT_W-1:0] flags_upd;

  function automatic logic is_spi(input shp_mode_t m);
    return (m == SHP_MODE_SPI3) || (m == SHP_MODE_SPI4);
  endfunction : is_spi

  assign pins_a = '{bus_sel: bus_sel_pin, sdata: sdata_i, addr1: address_one_data_out_pin_i,
                    sclk: sclk_pin, addr0_sel: address_zero_select_pin};

  shp_pin_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pins_a(pins_a),
    .pins_s(pins_s)
  );

  always_comb begin
    st_nxt = st_r;
    sel_now = st_r.locked && is_spi(st_r.link.mode) && !pins_s.addr0_sel;
    // set wins over clear for the same flag
    flags_upd = (st_r.flags & ~status_clear) | status_event;

    // straps are caught only once the synchronisers hold real pin levels
    if (!st_r.locked) begin
      if (st_r.strap_cnt == `SHP_STRAP_WAIT) begin
        st_nxt.locked = 1'b1;
        if (pins_s.bus_sel == `SHP_SEL_TWO_WIRE) begin
          st_nxt.link.mode = SHP_MODE_I2C;
          st_nxt.link.dev_addr = {pins_s.addr1, pins_s.addr0_sel};
        end else begin
          st_nxt.link.mode = spi_three_wire ? SHP_MODE_SPI3 : SHP_MODE_SPI4;
          st_nxt.link.dev_addr = `SHP_ADDR_ZERO;
        end
      end else begin
        st_nxt.strap_cnt = st_r.strap_cnt + `SHP_CNT_ONE;
      end
    end

    st_nxt.prev_sclk = pins_s.sclk;
    st_nxt.link.sclk_level = pins_s.sclk;
    st_nxt.link.sclk_rise = pins_s.sclk && !st_r.prev_sclk;
    st_nxt.link.sclk_fall = !pins_s.sclk && st_r.prev_sclk;
    st_nxt.link.selected = sel_now;
    st_nxt.link.data_in = pins_s.sdata;

    st_nxt.sdata = '{o: 1'b0, oe: 1'b0};
    st_nxt.addr1 = '{o: 1'b0, oe: 1'b0};
    case (st_r.link.mode)
      SHP_MODE_I2C: begin
        st_nxt.sdata = '{o: 1'b0, oe: tx.tx_en && !tx.tx_bit};
      end
      SHP_MODE_SPI3: begin
        st_nxt.sdata = '{o: tx.tx_bit, oe: tx.tx_en && sel_now};
      end
      SHP_MODE_SPI4: begin
        st_nxt.addr1 = '{o: tx.tx_bit, oe: sel_now};
      end
      default: begin
        st_nxt.sdata = '{o: 1'b0, oe: 1'b0};
      end
    endcase

    st_nxt.flags = flags_upd;
    st_nxt.irq_n = ~|(flags_upd & status_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.irq_n <= 1'b1;
      st_r.link.mode <= SHP_MODE_NONE;
      st_r.strap_cnt <= `SHP_CNT_ZERO;
      st_r.flags <= `SHP_STAT_CLEAR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sdata_o = st_r.sdata.o;
  assign sdata_oe = st_r.sdata.oe;
  assign address_one_data_out_pin_o = st_r.addr1.o;
  assign address_one_data_out_pin_oe = st_r.addr1.oe;
  assign link = st_r.link;
  assign status_flags = st_r.flags;
  assign status_change_irq_n = st_r.irq_n;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sclk_low;
    !pins_s.sclk;
  endsequence

  sequence s_sclk_high;
    pins_s.sclk;
  endsequence

  sequence s_lock_now;
    !st_r.locked && (st_r.strap_cnt == `SHP_STRAP_WAIT);
  endsequence

  a_strap_two_wire: assert property (
    s_lock_now ##0 pins_s.bus_sel |=> (st_r.link.mode == SHP_MODE_I2C) && st_r.locked)
    else $error("two-wire strap did not select two-wire mode");

  a_strap_spi: assert property (
    s_lock_now ##0 !pins_s.bus_sel |=> is_spi(st_r.link.mode))
    else $error("spi strap did not select spi mode");

  a_mode_held: assert property (
    st_r.locked |=> $stable(st_r.link.mode))
    else $error("mode changed after strap was caught");

  a_two_wire_od: assert property (
    (st_r.link.mode == SHP_MODE_I2C) |-> !sdata_o && !address_one_data_out_pin_oe)
    else $error("two-wire data pin driven high or data out pin driven");

  a_two_wire_pull: assert property (
    (st_r.link.mode == SHP_MODE_I2C) && tx.tx_en && !tx.tx_bit |=> sdata_oe)
    else $error("two-wire data pin not pulled low for a zero");

  a_spi4_input: assert property (
    (st_r.link.mode == SHP_MODE_SPI4) |-> !sdata_oe)
    else $error("four-wire spi drove the data input pin");

  a_spi3_drive: assert property (
    (st_r.link.mode == SHP_MODE_SPI3) && tx.tx_en && !pins_s.addr0_sel
      |=> sdata_oe && (sdata_o == $past(tx.tx_bit)))
    else $error("three-wire spi did not drive the data pin");

  a_spi4_dout: assert property (
    (st_r.link.mode == SHP_MODE_SPI4) && !pins_s.addr0_sel
      |=> address_one_data_out_pin_oe && (address_one_data_out_pin_o == $past(tx.tx_bit)))
    else $error("four-wire spi did not drive data out");

  a_addr_strap: assert property (
    s_lock_now ##0 pins_s.bus_sel
      |=> link.dev_addr == {$past(pins_s.addr1), $past(pins_s.addr0_sel)})
    else $error("address straps not caught");

  a_sclk_rise: assert property (
    s_sclk_low ##1 s_sclk_high |=> link.sclk_rise ##1 !link.sclk_rise)
    else $error("serial clock rising edge missed");

  a_cs_deselect: assert property (
    pins_s.addr0_sel |=> !link.selected)
    else $error("device selected while chip select high");

  a_irq_set: assert property (
    |(status_event & status_mask) |=> !status_change_irq_n)
    else $error("unmasked status change did not raise interrupt");

  // mask must be steady in the sampled cycle, the next irq level is built from it
  a_irq_hold: assert property (
    !status_change_irq_n && !(|status_clear) && $stable(status_mask)
      |=> !status_change_irq_n)
    else $error("interrupt released without a clear");

  a_irq_release: assert property (
    ~|(status_flags & ~status_clear & status_mask) && ~|status_event && $stable(status_mask)
      |=> status_change_irq_n)
    else $error("interrupt stayed low with nothing pending");

endmodule : shp_serial_port

// File: verification/shp_host_model.sv
`timescale 1ns/10ps
module shp_host_model (
  input wire logic frame, // host opens a transfer
  input wire logic i2c, // line is open drain with pull-up
  input wire logic dev_oe, // device drives the data line
  input wire logic dev_o, // device data level
  output logic sclk, // host serial clock
  output logic cs_n, // chip select, active low
  output logic sdata // resolved data line level
);
  logic host_bit;
  logic pat;
  logic host_drv;
  initial begin
    sclk = 1'b0;
    host_bit = 1'b1;
    pat = 1'b0;
    #5;
    forever begin
      #32;
      pat = !pat;
      sclk = frame ? !sclk : 1'b0;
    end
  end
  always @(negedge sclk) begin
    host_bit = !host_bit;
  end
  assign cs_n = !frame;
  assign host_drv = frame && !dev_oe;
  always_comb begin
    if (i2c) sdata = !((dev_oe && !dev_o) || (host_drv && !host_bit));
    else if (dev_oe) sdata = dev_o;
    else if (host_drv) sdata = host_bit;
    else sdata = pat; // released spi line must not look held
  end
endmodule : shp_host_model

// File: verification/tb_shp_serial_port.sv
`timescale 1ns/10ps
module tb_shp_serial_port;
  import shp_pkg::*;
  logic ref_clk, reset_n, bus_sel, three, a0, a1, frame;
  logic sd_o, sd_oe, a1_o, a1_oe, sclk, cs_n, sdata, irq_n;
  shp_tx_t tx;
  shp_link_t link;
  logic [7:0] ev, mask, clr, flags;
  int error_cnt = 0;
  int n_checks = 0;
  int rises;
  int falls;
  shp_host_model i_host (.frame(frame), .i2c(bus_sel), .dev_oe(sd_oe), .dev_o(sd_o),
    .sclk(sclk), .cs_n(cs_n), .sdata(sdata));
  shp_serial_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_sel_pin(bus_sel),
    .sdata_i(sdata), .sdata_o(sd_o), .sdata_oe(sd_oe),
    .address_one_data_out_pin_i(a1_oe ? a1_o : a1),
    .address_one_data_out_pin_o(a1_o), .address_one_data_out_pin_oe(a1_oe),
    .sclk_pin(sclk), .address_zero_select_pin(bus_sel ? a0 : cs_n),
    .spi_three_wire(three), .tx(tx), .link(link), .status_event(ev),
    .status_mask(mask), .status_clear(clr), .status_flags(flags),
    .status_change_irq_n(irq_n));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = !ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // straps are caught once, so each mode needs its own reset
  task automatic boot(input logic sel, input logic thr, input logic b0, input logic b1);
    bus_sel = sel;
    three = thr;
    a0 = b0;
    a1 = b1;
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(6);
  endtask : boot
  task automatic t_i2c;
    boot(1'b1, 1'b0, 1'b1, 1'b0);
    chk("mode", {6'h0, SHP_MODE_I2C}, {6'h0, link.mode});
    chk("addr", 8'h01, {6'h0, link.dev_addr});
    tx = '{tx_en: 1'b1, tx_bit: 1'b0};
    tick(1);
    chk("sda_oe", 8'h01, {7'h0, sd_oe});
    chk("sda", 8'h00, {7'h0, sdata});
    chk("a1_oe", 8'h00, {7'h0, a1_oe});
    tx.tx_bit = 1'b1;
    tick(1);
    chk("sda_rel", 8'h00, {7'h0, sd_oe});
    tx = '0;
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    chk("addr1", 8'h02, {6'h0, link.dev_addr});
  endtask : t_i2c
  task automatic t_spi4;
    boot(1'b0, 1'b0, 1'b1, 1'b1);
    chk("mode4", {6'h0, SHP_MODE_SPI4}, {6'h0, link.mode});
    chk("addr0", 8'h00, {6'h0, link.dev_addr});
    tx = '{tx_en: 1'b1, tx_bit: 1'b1};
    tick(4);
    chk("unsel", 8'h00, {6'h0, link.selected, a1_oe});
    frame = 1'b1;
    tick(4);
    chk("sdo", 8'h03, {6'h0, a1_oe, a1_o});
    tx = '0;
    tick(1);
    chk("sdo0", 8'h02, {6'h0, a1_oe, a1_o});
    rises = 0;
    falls = 0;
    repeat (40) begin
      tick(1);
      chk("sdi_oe", 8'h00, {7'h0, sd_oe});
      if (link.sclk_rise === 1'b1) begin
        rises++;
        chk("sdi", {7'h0, sdata}, {7'h0, link.data_in});
        chk("rise_lvl", 8'h01, {7'h0, link.sclk_level});
      end
      if (link.sclk_fall === 1'b1) begin
        falls++;
        chk("fall_lvl", 8'h00, {7'h0, link.sclk_level});
      end
    end
    frame = 1'b0;
    chk("rises", 8'h01, {7'h0, rises >= 4});
    chk("falls", 8'h01, {7'h0, falls >= 4});
  endtask : t_spi4
  task automatic t_spi3;
    boot(1'b0, 1'b1, 1'b1, 1'b1);
    chk("mode3", {6'h0, SHP_MODE_SPI3}, {6'h0, link.mode});
    frame = 1'b1;
    tick(4);
    tx = '{tx_en: 1'b1, tx_bit: 1'b1};
    tick(1);
    chk("sdio", 8'h06, {5'h0, sd_oe, sdata, a1_oe});
    tx = '0;
    tick(1);
    chk("sdio_rel", 8'h00, {7'h0, sd_oe});
    frame = 1'b0;
  endtask : t_spi3
  task automatic t_irq;
    ev = 8'h04;
    tick(1);
    ev = 8'h00;
    chk("flags", 8'h04, flags);
    chk("irq", 8'h00, {7'h0, irq_n});
    mask = 8'hfb;
    tick(1);
    chk("irq_mask", 8'h01, {7'h0, irq_n});
    mask = 8'hff;
    {ev, clr} = 16'h0404;
    tick(1);
    {ev, clr} = 16'h0000;
    chk("set_wins", 8'h04, {flags[7:1], irq_n});
    clr = 8'h04;
    tick(1);
    clr = 8'h00;
    chk("cleared", 8'h01, {flags[7:1], irq_n});
  endtask : t_irq
  initial begin
    {reset_n, bus_sel, three, a0, a1, frame} = 6'h00;
    {tx, ev, clr} = '0;
    mask = 8'hff;
    t_i2c();
    t_spi4();
    t_spi3();
    t_irq();
    end_of_test();
  end
  // whole run is about 93 cycles
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb_shp_serial_port
